// ==== ftel_flash_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// flash array stand-in: counts the commands it receives
// ****************************************************************
module ftel_flash_model (
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  input  wire logic erase0_i,
  input  wire logic erase1_i,
  input  wire logic write_i,
  output var  int   erase0_cnt_o,
  output var  int   erase1_cnt_o,
  output var  int   write_cnt_o
);
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      erase0_cnt_o <= 0;
      erase1_cnt_o <= 0;
      write_cnt_o  <= 0;
    end
    else
    begin
      erase0_cnt_o <= erase0_cnt_o + int'(erase0_i);
      erase1_cnt_o <= erase1_cnt_o + int'(erase1_i);
      write_cnt_o  <= write_cnt_o + int'(write_i);
    end
  end
endmodule
`default_nettype wire

// ==== ftel_pkg.sv ====
// Functional notes
// - tick select bit: 0 means count spans 1 us, 1 means 5 us.
// - six-bit cycle count, reset 0x10, times flash writes and erases.
// - writing key 0x631A unlocks both mass-erase commands.
// - writing any other key value locks both mass-erase commands.
// - lock reads bit 0 as 1 when locked; reset value 0x0001, locked.
package ftel_pkg;
  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0]  FTEL_LOCK_OFS      = 8'h54;
  localparam logic [7:0]  FTEL_TIMING_OFS    = 8'h50;
  localparam logic [7:0]  FTEL_CMD_OFS       = 8'h58;
  localparam logic [7:0]  FTEL_STATUS_OFS    = 8'h5C;
  localparam logic [15:0] FTEL_UNLOCK_CODE   = 16'h631A;
  localparam logic [15:0] FTEL_LOCK_RESET    = 16'h0001;
  localparam logic [5:0]  FTEL_BASE_RESET    = 6'h10;
  localparam int          FTEL_SEL_BIT       = 16;
  localparam int          FTEL_CMD_BANK0_BIT = 0;
  localparam int          FTEL_CMD_BANK1_BIT = 1;
  localparam int          FTEL_CMD_WRITE_BIT = 2;
  localparam int          FTEL_CMD_ERASE_BIT = 3;
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int          FTEL_ERASE_TICKS   = 16;
  localparam int          FTEL_WRITE_TICKS   = 4;

  typedef enum logic [1:0] {
    FTEL_IDLE = 2'b01,
    FTEL_BUSY = 2'b10
  } ftel_state_t;
endpackage

// ==== ftel_top.sv ====
// Register access over Avalon-MM was decided locally.
`timescale 1ns/1ps
`default_nettype none
module ftel_top (
  // clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              reset_n_i,
  // auxiliary fast oscillator cycles, one pulse per cycle
  input  wire logic              aux_fast_oscillator_i,
  // avalon-mm slave
  input  wire logic [7:0]        avs_address_i,
  input  wire logic              avs_read_i,
  input  wire logic              avs_write_i,
  input  wire logic [31:0]       avs_writedata_i,
  output logic      [31:0]       avs_readdata_o,
  output logic                   avs_waitrequest_o,
  // flash array side
  output logic                   erase_bank_zero_cmd_o,
  output logic                   erase_bank_one_cmd_o,
  output logic                   flash_write_cmd_o,
  output logic                   flash_busy_o,
  output logic                   tick_o
);
  import ftel_pkg::*;

  typedef struct packed {
    logic [15:0]  key;
    logic [5:0]   base;
    logic         sel;
    logic [5:0]   aux_cnt;
    logic [2:0]   sub_cnt;
    logic         tick;
    logic [4:0]   op_ticks;
    ftel_state_t  state;
    logic         bank0;
    logic         bank1;
    logic         wr;
    logic         ack;
    logic [31:0]  rdata;
  } ftel_regs_t;

  ftel_regs_t st_reg;
  ftel_regs_t st_next;
  logic       locked;
  logic       acc;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  assign locked = (st_reg.key != FTEL_UNLOCK_CODE);
  assign acc    = (avs_read_i | avs_write_i) & ~st_reg.ack;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    st_next       = st_reg;
    st_next.ack   = acc;
    st_next.tick  = 1'b0;
    st_next.bank0 = 1'b0;
    st_next.bank1 = 1'b0;
    st_next.wr    = 1'b0;
    // tick: base aux cycles, times five when 5 us selected
    if (aux_fast_oscillator_i)
    begin
      if (st_reg.aux_cnt >= st_reg.base - 6'h01)
      begin
        st_next.aux_cnt = 6'h00;
        if (!st_reg.sel || st_reg.sub_cnt == 3'h4)
        begin
          st_next.sub_cnt = 3'h0;
          st_next.tick    = 1'b1;
        end
        else
          st_next.sub_cnt = st_reg.sub_cnt + 3'h1;
      end
      else
        st_next.aux_cnt = st_reg.aux_cnt + 6'h01;
    end
    // operation timer in ticks
    case (st_reg.state)
      FTEL_IDLE: ;
      FTEL_BUSY:
      begin
        if (st_reg.tick)
        begin
          if (st_reg.op_ticks == 5'h00)
            st_next.state = FTEL_IDLE;
          else
            st_next.op_ticks = st_reg.op_ticks - 5'h01;
        end
      end
      default: st_next.state = FTEL_IDLE;
    endcase
    if (acc && avs_write_i)
    begin
      if (hit(avs_address_i, FTEL_LOCK_OFS))
        st_next.key = avs_writedata_i[15:0];
      else if (hit(avs_address_i, FTEL_TIMING_OFS))
      begin
        st_next.base = avs_writedata_i[5:0];
        st_next.sel  = avs_writedata_i[FTEL_SEL_BIT];
        st_next.aux_cnt = 6'h00;
        st_next.sub_cnt = 3'h0;
      end
      else if (hit(avs_address_i, FTEL_CMD_OFS) &&
               st_reg.state == FTEL_IDLE)
      begin
        if (avs_writedata_i[FTEL_CMD_WRITE_BIT])
        begin
          st_next.wr       = 1'b1;
          st_next.state    = FTEL_BUSY;
          st_next.op_ticks = 5'(FTEL_WRITE_TICKS - 1);
        end
        else if (!locked && (avs_writedata_i[FTEL_CMD_BANK0_BIT] ||
                 avs_writedata_i[FTEL_CMD_BANK1_BIT]))
        begin
          st_next.bank0    = avs_writedata_i[FTEL_CMD_BANK0_BIT];
          st_next.bank1    = avs_writedata_i[FTEL_CMD_BANK1_BIT];
          st_next.state    = FTEL_BUSY;
          st_next.op_ticks = 5'(FTEL_ERASE_TICKS - 1);
        end
      end
    end
    st_next.rdata = 32'h0000_0000;
    if (acc && avs_read_i)
    begin
      if (hit(avs_address_i, FTEL_LOCK_OFS))
        st_next.rdata[0] = locked;
      else if (hit(avs_address_i, FTEL_TIMING_OFS))
      begin
        st_next.rdata[5:0]          = st_reg.base;
        st_next.rdata[FTEL_SEL_BIT] = st_reg.sel;
      end
      else if (hit(avs_address_i, FTEL_STATUS_OFS))
        st_next.rdata[1:0] = {locked, st_reg.state == FTEL_BUSY};
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      st_reg       <= '0;
      st_reg.key   <= FTEL_LOCK_RESET;
      st_reg.base  <= FTEL_BASE_RESET;
      st_reg.state <= FTEL_IDLE;
    end
    else
      st_reg <= st_next;
  end

  assign avs_waitrequest_o     = ~st_reg.ack;
  assign avs_readdata_o        = st_reg.rdata;
  assign erase_bank_zero_cmd_o = st_reg.bank0;
  assign erase_bank_one_cmd_o  = st_reg.bank1;
  assign flash_write_cmd_o     = st_reg.wr;
  assign flash_busy_o          = (st_reg.state == FTEL_BUSY);
  assign tick_o                = st_reg.tick;

  // ****************************************************************
  // checks
  // ****************************************************************
  erase_gate_a: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    (erase_bank_zero_cmd_o | erase_bank_one_cmd_o) |-> !$past(locked))
    else $error("mass erase issued while locked");
  cmd_gate_a: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    (acc && avs_write_i && avs_address_i == FTEL_CMD_OFS && locked
     && !flash_busy_o && !avs_writedata_i[FTEL_CMD_WRITE_BIT]) |=>
      !flash_busy_o && !erase_bank_zero_cmd_o && !erase_bank_one_cmd_o)
    else $error("locked mass erase was not dropped");
  erase_start_a: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    (acc && avs_write_i && avs_address_i == FTEL_CMD_OFS && !locked
     && !flash_busy_o && !avs_writedata_i[FTEL_CMD_WRITE_BIT]
     && (avs_writedata_i[FTEL_CMD_BANK0_BIT]
         || avs_writedata_i[FTEL_CMD_BANK1_BIT])) |=>
      flash_busy_o
      && erase_bank_zero_cmd_o == $past(avs_writedata_i[FTEL_CMD_BANK0_BIT])
      && erase_bank_one_cmd_o == $past(avs_writedata_i[FTEL_CMD_BANK1_BIT]))
    else $error("unlocked mass erase not issued");
  unlock_key_a: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    (acc && avs_write_i && avs_address_i == FTEL_LOCK_OFS
     && avs_writedata_i[15:0] == FTEL_UNLOCK_CODE) |=> !locked)
    else $error("unlock code did not unlock");
  lock_key_a: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    (acc && avs_write_i && avs_address_i == FTEL_LOCK_OFS
     && avs_writedata_i[15:0] != FTEL_UNLOCK_CODE) |=> locked)
    else $error("other key did not lock");
  lock_read_a: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    (acc && avs_read_i && avs_address_i == FTEL_LOCK_OFS) |=>
      avs_readdata_o == {31'h0, $past(locked)})
    else $error("lock readback wrong");
  status_read_a: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    (acc && avs_read_i && avs_address_i == FTEL_STATUS_OFS) |=>
      avs_readdata_o == {30'h0000_0000, $past(locked), $past(flash_busy_o)})
    else $error("status readback wrong");
  timing_read_a: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    (acc && avs_read_i && avs_address_i == FTEL_TIMING_OFS) |=>
      avs_readdata_o == {15'h0000, $past(st_reg.sel), 10'h000,
                         $past(st_reg.base)})
    else $error("timing readback wrong");
  unmapped_read_a: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    (acc && avs_read_i && avs_address_i != FTEL_LOCK_OFS
     && avs_address_i != FTEL_TIMING_OFS
     && avs_address_i != FTEL_STATUS_OFS) |=>
      avs_readdata_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  base_reg_a: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    (acc && avs_write_i && avs_address_i == FTEL_TIMING_OFS) |=>
      st_reg.base == $past(avs_writedata_i[5:0]))
    else $error("cycle count not stored");
  tick_period_a: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    (tick_o && $past(st_reg.sel)) |-> $past(st_reg.sub_cnt) == 3'h4)
    else $error("tick length select ignored");
endmodule
`default_nettype wire

// ==== tb_flash_timing_and_erase_lock.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_flash_timing_and_erase_lock;
  import ftel_pkg::*;
  logic        clk = 0, rst_n = 0, aux = 0, rd = 0, wr = 0;
  logic [7:0]  addr = '0;
  logic [31:0] wdata = '0, rdata, q;
  logic        wrq, e0, e1, fw, busy, tick;
  int          err_count = 0, total_checks = 0, c0, c1, cw, gap;
  realtime     t0;
  ftel_top dut_u (.core_clk_i(clk), .reset_n_i(rst_n),
    .aux_fast_oscillator_i(aux), .avs_address_i(addr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdata), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wrq), .erase_bank_zero_cmd_o(e0),
    .erase_bank_one_cmd_o(e1), .flash_write_cmd_o(fw),
    .flash_busy_o(busy), .tick_o(tick));
  ftel_flash_model flash_u (.clk_i(clk), .reset_n_i(rst_n), .erase0_i(e0),
    .erase1_i(e1), .write_i(fw), .erase0_cnt_o(c0), .erase1_cnt_o(c1),
    .write_cnt_o(cw));
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  // aux strobe every second clock
  always @(posedge clk) aux <= ~aux;
  task automatic chk(input string n, input logic [31:0] s, e);
    total_checks++;
    if (s !== e)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= w;
    rd    <= !w;
    do @(posedge clk); while (wrq !== 1'b0);
    q = rdata;
    wr <= 0;
    rd <= 0;
  endtask
  task automatic tick_gap();
    @(posedge tick);
    @(posedge tick);
    t0 = $realtime;
    @(posedge tick);
    gap = int'(($realtime - t0) / 25.0);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    #500000;
    err_count++;
    close_out();
  end
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1;
    bus(0, FTEL_LOCK_OFS, 0);
    chk("lock reset", q, 32'h0000_0001);
    bus(0, FTEL_TIMING_OFS, 0);
    chk("timing reset", q, 32'h0000_0010);
    tick_gap();
    chk("tick gap reset", gap, 32);
    bus(0, 8'h40, 32'h0000_0000);
    chk("unmapped read", q, 32'h0000_0000);
    $display("test reset done");
    bus(1, FTEL_CMD_OFS, 32'h0000_0003);
    repeat (4) @(posedge clk);
    chk("locked erases", c0 + c1, 0);
    bus(1, FTEL_LOCK_OFS, {16'h0000, FTEL_UNLOCK_CODE});
    bus(0, FTEL_LOCK_OFS, 0);
    chk("lock open", q, 32'h0000_0000);
    bus(1, FTEL_CMD_OFS, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chk("erase bank0", c0, 1);
    chk("busy", busy, 1'b1);
    bus(1, FTEL_CMD_OFS, 32'h0000_0004);
    repeat (2) @(posedge clk);
    chk("write while busy", cw, 0);
    wait (busy === 1'b0);
    bus(1, FTEL_CMD_OFS, 32'h0000_0004);
    repeat (2) @(posedge clk);
    chk("write cmd", cw, 1);
    wait (busy === 1'b0);
    bus(1, FTEL_CMD_OFS, 32'h0000_0002);
    repeat (2) @(posedge clk);
    chk("erase bank1", c1, 1);
    wait (busy === 1'b0);
    bus(1, FTEL_LOCK_OFS, 32'h0000_1234);
    bus(0, FTEL_LOCK_OFS, 0);
    chk("relock", q, 32'h0000_0001);
    bus(0, FTEL_STATUS_OFS, 0);
    chk("status locked", q, 32'h0000_0002);
    bus(1, FTEL_CMD_OFS, 32'h0000_0002);
    repeat (4) @(posedge clk);
    chk("erase bank1 locked", c1, 1);
    $display("test lock done");
    bus(1, FTEL_TIMING_OFS, 32'h0001_0004);
    bus(0, FTEL_TIMING_OFS, 0);
    chk("timing read", q, 32'h0001_0004);
    tick_gap();
    chk("tick gap five", gap, 40);
    bus(1, FTEL_TIMING_OFS, 32'h0000_0004);
    tick_gap();
    chk("tick gap one", gap, 8);
    $display("test timing done");
    close_out();
  end
endmodule
`default_nettype wire
